// file: src/tx_test_map.svh
`ifndef TX_TEST_MAP_SVH
`define TX_TEST_MAP_SVH
// device register addresses on the link
`define A_MAIN       8'h00
`define A_TX_CTRL    8'h01
`define A_MODEM      8'h02
`define A_DAC_OVR    8'h03
`define A_MONITOR    8'h04
`define A_ISTAT      8'h05
`define A_IMASK      8'h06
`define A_TXBUF      8'h07
// command strobe codes, carried on addr while stb is high
`define S_OSC_ON     8'h01
`define S_TX_ON      8'h02
`define S_RF_OFF     8'h03
// field positions
`define BYPASS_BIT   0
`define OSC_BIT      1
`define ACTIVE_BIT   2
`define PWR_MSB      4
`define SEL_MSB      3
`define SEL_LSB      2
`define THR_MSB      4
`define MON_EN_BIT   5
`define MON_OK_BIT   6
`define IRQ_SYNC     0
`define IRQ_DONE     1
`define IRQ_LOW      2
// reset and special values
`define TX_CTRL_RST  16'ha0ff
`define TX_CTRL_FIX  16'ha0e0
`define DAC_CARRIER  16'h1800
`define PREAMBLE_LEN 3'h4
`define PREAMBLE_BYTE 8'h00
`define SFD_BYTE     8'ha7
`define CRC_POLY     16'h8408
`define CRC_FEED     8'hff
`define BUF_FULL     8'h80
// supply monitor threshold terms, millivolts
`define VREF_MV      17'h004e2
`define THR_BASE     17'h00048
`define THR_DIV      17'h0001b
// timing
`define CLK_NS       50
`define BYTE_NS      32000
`define REG_WAIT_NS  100000
`define SETTLE_NS    2000
// host register addresses and control register bits
`define H_TARGET     8'h00
`define H_WRITE      8'h01
`define H_STROBE     8'h02
`define H_READ       8'h03
`define H_RESULT     8'h04
`define H_CTRL       8'h05
`define H_POWER      8'h06
`define H_CLKSRC     8'h07
`define H_ISTAT      8'h08
`define H_IMASK      8'h09
`define REG_BIT      0
`define RST_BIT      1
`define READY_BIT    2
// host status bits
`define HIRQ_READ    0
`define HIRQ_DEV     1
`define HIRQ_RDY     2
`endif

// file: src/tx_test_pkg.sv
`default_nettype none
`include "tx_test_map.svh"
package tx_test_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef logic [11:0] mv_t;
  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_HEADER = 2'b01,
    TX_DATA   = 2'b10
  } tx_state_e;
  typedef enum logic [1:0] {
    SEL_NORMAL = 2'b00,
    SEL_SPARE  = 2'b01,
    SEL_LOOP   = 2'b10,
    SEL_PRBS   = 2'b11
  } tx_sel_e;
  typedef struct packed {
    word_t                 tx_ctrl;
    logic                  bypass;
    logic                  osc_on;
    tx_sel_e               sel;
    word_t                 dac_ovr;
    logic                  mon_en;
    logic [4:0]            thr;
    logic                  mon_ok;
    logic [2:0]            ist;
    logic [2:0]            imask;
    logic                  irq;
    word_t                 rdata;
    logic [127:0][7:0]     buf_mem;
    logic [6:0]            wptr;
    logic [6:0]            rptr;
    logic [7:0]            fill;
    tx_state_e             state;
    logic [2:0]            hdr;
    logic [15:0]           bcnt;
    word_t                 crc;
    byte_t                 txb;
    logic                  stb;
    logic                  carrier;
    logic                  bias;
    mv_t                   sup_s1;
    mv_t                   sup_s2;
  } dev_s;
  typedef struct packed {
    byte_t                 target;
    logic                  l_wr;
    logic                  l_rd;
    logic                  l_stb;
    logic                  l_rst;
    byte_t                 l_addr;
    word_t                 l_data;
    logic                  pend;
    word_t                 result;
    logic                  reg_en;
    logic                  off_pend;
    logic [2:0]            ist;
    logic [2:0]            imask;
    logic                  irq;
    word_t                 rdata;
    logic                  dirq_d;
    logic                  rdy_d;
    logic [11:0]           wait_cnt;
    logic [7:0]            settle_cnt;
  } host_s;
endpackage
`default_nettype wire

// file: src/radio_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface radio_link_if (
  input wire logic clk
);
  logic        wr_en;
  logic        rd_en;
  logic        stb;
  logic        reset_req;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        regulator_enable_pin;
  logic        irq;
  modport device (
    input  wr_en, rd_en, stb, reset_req, addr, wdata, regulator_enable_pin,
    output rdata, irq
  );
  modport host (
    output wr_en, rd_en, stb, reset_req, addr, wdata, regulator_enable_pin,
    input  rdata, irq
  );
endinterface
`default_nettype wire

// file: src/rf_test_power_ctrl.sv
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tx_test_map.svh"
module rf_test_power_ctrl #(
  parameter int BYTE_CYCLES = `BYTE_NS / `CLK_NS
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // link to host
  radio_link_if.device            lnk,
  // unregulated supply level, millivolts
  input  wire tx_test_pkg::mv_t   supply_mv,
  // radio controls
  output logic [4:0]              output_power_level,
  output logic                    oscillator_bypass,
  output logic                    osc_enabled,
  output logic                    bias_switch_output,
  output logic                    dac_static,
  output logic                    supply_above_threshold,
  // transmitted byte stream
  output tx_test_pkg::byte_t      tx_byte,
  output logic                    tx_byte_stb
);
  import tx_test_pkg::*;

  if (BYTE_CYCLES < 2 || BYTE_CYCLES > 65536) begin : g_bad_byte_cycles
    $error("BYTE_CYCLES out of range");
  end

  dev_s        q;
  dev_s        n;
  logic        mon_valid;
  logic [16:0] mon_lhs;
  logic [16:0] mon_rhs;
  logic [2:0]  set;
  logic [2:0]  clr;
  logic        fill_inc;
  logic        fill_dec;

  // one crc step over a byte, lsb first
  function automatic word_t crc_step(input word_t c, input byte_t d);
    word_t r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // next state of the whole device
  always_comb begin
    n = q;
    set = 3'h0;
    clr = 3'h0;
    fill_inc = 1'b0;
    fill_dec = 1'b0;
    n.stb = 1'b0;
    n.rdata = 16'h0000;
    n.sup_s1 = supply_mv;
    n.sup_s2 = q.sup_s1;

    // byte timer and transmit sequencer
    if (q.state != TX_IDLE) begin
      if (q.bcnt != 16'h0000) begin
        n.bcnt = q.bcnt - 16'h0001;
      end else begin
        n.bcnt = 16'(BYTE_CYCLES - 1);
        n.stb = 1'b1;
        if (q.state == TX_HEADER) begin
          if (q.hdr != `PREAMBLE_LEN) begin
            n.txb = `PREAMBLE_BYTE;
            n.hdr = q.hdr + 3'h1;
          end else begin
            n.txb = `SFD_BYTE;
            n.state = TX_DATA;
            set[`IRQ_SYNC] = 1'b1;
          end
        end else begin
          case (q.sel)
            SEL_PRBS: begin
              // period of 65534 bits from the crc register
              n.txb = q.crc[7:0];
              n.crc = crc_step(q.crc, `CRC_FEED);
            end
            SEL_LOOP: begin
              // pointer wraps at 128, empty buffer not checked
              n.txb = q.buf_mem[q.rptr];
              n.rptr = q.rptr + 7'h01;
            end
            default: begin
              if (q.fill == 8'h00) begin
                n.stb = 1'b0;
                n.state = TX_IDLE;
                set[`IRQ_DONE] = 1'b1;
              end else begin
                n.txb = q.buf_mem[q.rptr];
                n.rptr = q.rptr + 7'h01;
                fill_dec = 1'b1;
              end
            end
          endcase
        end
      end
    end

    // register writes
    if (lnk.wr_en) begin
      case (lnk.addr)
        `A_MAIN: n.bypass = lnk.wdata[`BYPASS_BIT];
        `A_TX_CTRL: n.tx_ctrl = lnk.wdata;
        `A_MODEM: n.sel = tx_sel_e'(lnk.wdata[`SEL_MSB:`SEL_LSB]);
        `A_DAC_OVR: n.dac_ovr = lnk.wdata;
        `A_MONITOR: begin
          n.mon_en = lnk.wdata[`MON_EN_BIT];
          n.thr = lnk.wdata[`THR_MSB:0];
        end
        `A_ISTAT: clr = lnk.wdata[2:0];
        `A_IMASK: n.imask = lnk.wdata[2:0];
        `A_TXBUF: begin
          // a write into a full buffer is dropped
          if (q.fill != `BUF_FULL) begin
            n.buf_mem[q.wptr] = lnk.wdata[7:0];
            n.wptr = q.wptr + 7'h01;
            fill_inc = 1'b1;
          end
        end
        default: ;
      endcase
    end
    n.fill = q.fill + {7'h00, fill_inc} - {7'h00, fill_dec};

    // register reads, answered in the next cycle
    if (lnk.rd_en) begin
      case (lnk.addr)
        `A_MAIN: begin
          n.rdata[`BYPASS_BIT] = q.bypass;
          n.rdata[`OSC_BIT] = q.osc_on;
          n.rdata[`ACTIVE_BIT] = q.bias;
        end
        `A_TX_CTRL: n.rdata = q.tx_ctrl;
        `A_MODEM: n.rdata[`SEL_MSB:`SEL_LSB] = q.sel;
        `A_DAC_OVR: n.rdata = q.dac_ovr;
        `A_MONITOR: begin
          n.rdata[`THR_MSB:0] = q.thr;
          n.rdata[`MON_EN_BIT] = q.mon_en;
          n.rdata[`MON_OK_BIT] = q.mon_ok;
        end
        `A_ISTAT: n.rdata[2:0] = q.ist;
        `A_IMASK: n.rdata[2:0] = q.imask;
        default: ;
      endcase
    end

    // command strobes
    if (lnk.stb) begin
      case (lnk.addr)
        `S_OSC_ON: n.osc_on = 1'b1;
        `S_TX_ON: begin
          if (q.state == TX_IDLE) begin
            n.state = TX_HEADER;
            n.hdr = 3'h0;
            n.bcnt = 16'h0000;
            n.crc = 16'h0000;
            n.carrier = q.sel[1] && (q.dac_ovr == `DAC_CARRIER);
          end
        end
        `S_RF_OFF: begin
          // a looped buffer is flushed when the test ends
          n.stb = 1'b0;
          n.state = TX_IDLE;
          if (q.sel == SEL_LOOP) begin
            n.rptr = q.wptr;
            n.fill = 8'h00;
          end
        end
        default: ;
      endcase
    end

    // supply monitor compare: supply*27 against 1250*(72-N)
    mon_valid = q.mon_en && lnk.regulator_enable_pin;
    mon_lhs = {5'h00, q.sup_s2} * `THR_DIV;
    mon_rhs = `VREF_MV * (`THR_BASE - {12'h000, q.thr});
    n.mon_ok = mon_valid && (mon_lhs > mon_rhs);
    set[`IRQ_LOW] = q.mon_ok && !n.mon_ok;

    // bias follows transmit state
    n.bias = (n.state != TX_IDLE);
    n.carrier = n.carrier && n.bias;

    // sticky status, set wins over clear
    n.ist = (q.ist & ~clr) | set;
    n.irq = |(n.ist & n.imask);

    // host reset request returns everything to reset
    if (lnk.reset_req) begin
      n = '0;
      n.tx_ctrl = `TX_CTRL_RST;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.tx_ctrl <= `TX_CTRL_RST;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops
  assign output_power_level = q.tx_ctrl[`PWR_MSB:0];
  assign oscillator_bypass = q.bypass;
  assign osc_enabled = q.osc_on;
  assign bias_switch_output = q.bias;
  assign dac_static = q.carrier;
  assign supply_above_threshold = q.mon_ok;
  assign tx_byte = q.txb;
  assign tx_byte_stb = q.stb;
  assign lnk.rdata = q.rdata;
  assign lnk.irq = q.irq;
endmodule
`default_nettype wire

// file: src/rf_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_test_map.svh"
module rf_host_ctrl #(
  parameter int REG_WAIT_CYC = (`REG_WAIT_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int SETTLE_CYC   = (`SETTLE_NS + `CLK_NS - 1) / `CLK_NS
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // software port
  input  wire tx_test_pkg::byte_t   addr,
  input  wire tx_test_pkg::word_t   wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output tx_test_pkg::word_t        rdata,
  output logic                      irq,
  // link to device
  radio_link_if.host                lnk
);
  import tx_test_pkg::*;

  if (REG_WAIT_CYC < 1 || REG_WAIT_CYC > 4095 ||
      SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_wait
    $error("wait counts out of range");
  end

  host_s      q;
  host_s      n;
  logic [2:0] set;
  logic [2:0] clr;
  logic       ready;

  // next state of the host
  always_comb begin
    n = q;
    set = 3'h0;
    clr = 3'h0;
    n.l_wr = 1'b0;
    n.l_rd = 1'b0;
    n.l_stb = 1'b0;
    n.l_rst = 1'b0;
    n.rdata = 16'h0000;
    ready = q.reg_en && q.wait_cnt == 12'h000 && q.settle_cnt == 8'h00;

    // capture the device answer two edges after issuing a read
    n.pend = q.l_rd;
    if (q.pend) begin
      n.result = lnk.rdata;
      set[`HIRQ_READ] = 1'b1;
    end

    // the regulator drops one cycle after the device reset pulse
    if (q.off_pend) begin
      n.reg_en = 1'b0;
      n.off_pend = 1'b0;
    end

    // software writes
    if (wr) begin
      case (addr)
        `H_TARGET: n.target = wdata[7:0];
        `H_WRITE: begin
          n.l_wr = 1'b1;
          n.l_addr = q.target;
          n.l_data = wdata;
        end
        `H_STROBE: begin
          n.l_stb = 1'b1;
          n.l_addr = wdata[7:0];
        end
        `H_READ: begin
          n.l_rd = 1'b1;
          n.l_addr = q.target;
        end
        `H_CTRL: begin
          if (wdata[`REG_BIT]) begin
            n.reg_en = 1'b1;
            n.off_pend = 1'b0;
          end else if (q.reg_en) begin
            n.l_rst = 1'b1;
            n.off_pend = 1'b1;
          end
          if (wdata[`RST_BIT]) begin
            n.l_rst = 1'b1;
          end
        end
        `H_POWER: begin
          n.l_wr = 1'b1;
          n.l_addr = `A_TX_CTRL;
          n.l_data = `TX_CTRL_FIX | {11'h000, wdata[4:0]};
        end
        `H_CLKSRC: begin
          n.l_wr = 1'b1;
          n.l_addr = `A_MAIN;
          n.l_data = {15'h0000, wdata[`BYPASS_BIT]};
        end
        `H_ISTAT: clr = wdata[2:0];
        `H_IMASK: n.imask = wdata[2:0];
        default: ;
      endcase
    end

    // software reads
    if (rd) begin
      case (addr)
        `H_TARGET: n.rdata[7:0] = q.target;
        `H_RESULT: n.rdata = q.result;
        `H_CTRL: begin
          n.rdata[`REG_BIT] = q.reg_en;
          n.rdata[`READY_BIT] = ready;
        end
        `H_ISTAT: n.rdata[2:0] = q.ist;
        `H_IMASK: n.rdata[2:0] = q.imask;
        default: ;
      endcase
    end

    // settle timers gate the monitor-ready flag
    if (n.reg_en && !q.reg_en) begin
      n.wait_cnt = 12'(REG_WAIT_CYC);
    end else if (q.wait_cnt != 12'h000) begin
      n.wait_cnt = q.wait_cnt - 12'h001;
    end
    if (n.l_wr && n.l_addr == `A_MONITOR) begin
      n.settle_cnt = 8'(SETTLE_CYC);
    end else if (q.settle_cnt != 8'h00) begin
      n.settle_cnt = q.settle_cnt - 8'h01;
    end
    n.rdy_d = ready;
    set[`HIRQ_RDY] = ready && !q.rdy_d;
    n.dirq_d = lnk.irq;
    set[`HIRQ_DEV] = lnk.irq && !q.dirq_d;

    // sticky status, set wins over clear
    n.ist = (q.ist & ~clr) | set;
    n.irq = |(n.ist & n.imask);
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops
  assign rdata = q.rdata;
  assign irq = q.irq;
  assign lnk.wr_en = q.l_wr;
  assign lnk.rd_en = q.l_rd;
  assign lnk.stb = q.l_stb;
  assign lnk.reset_req = q.l_rst;
  assign lnk.addr = q.l_addr;
  assign lnk.wdata = q.l_data;
  assign lnk.regulator_enable_pin = q.reg_en;
endmodule
`default_nettype wire

// file: dv/tx_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_test_map.svh"
module tx_link_checker #(
  parameter int BC = 4
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // link from host
  input wire logic        wr_en,
  input wire logic        stb,
  input wire logic        reset_req,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        regulator_enable_pin,
  // device outputs
  input wire logic [4:0]  output_power_level,
  input wire logic        oscillator_bypass,
  input wire logic        bias_switch_output,
  input wire logic        dac_static,
  input wire logic        supply_above_threshold,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_byte_stb
);
  logic [15:0] gap_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // cycles since the last byte of a running transmit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) gap_ff <= 16'h0000;
    else if (tx_byte_stb) gap_ff <= 16'h0001;
    else if (!bias_switch_output) gap_ff <= 16'h0000;
    else if (gap_ff != 16'h0000) gap_ff <= gap_ff + 16'h0001;
  end
  chk_power_write: assert property (
    wr_en && addr == `A_TX_CTRL && !reset_req |=> output_power_level == $past(wdata[4:0]))
    else $error("power level not taken from write");
  chk_power_hold: assert property (
    !(wr_en && addr == `A_TX_CTRL) && !reset_req |=> $stable(output_power_level))
    else $error("power level changed without write");
  chk_bypass_write: assert property (
    wr_en && addr == `A_MAIN && !reset_req |=> oscillator_bypass == $past(wdata[0]))
    else $error("bypass bit not taken from write");
  chk_monitor_noreg: assert property (
    !regulator_enable_pin [*2] |-> !supply_above_threshold)
    else $error("monitor status high without regulator");
  chk_reset_first: assert property (
    $fell(regulator_enable_pin) |-> $past(reset_req))
    else $error("regulator dropped without device reset");
  chk_bias_bytes: assert property (
    tx_byte_stb |-> bias_switch_output)
    else $error("byte sent while bias switch low");
  chk_tx_start: assert property (
    stb && addr == `S_TX_ON && !bias_switch_output && !reset_req
    |=> bias_switch_output ##1 (tx_byte_stb && tx_byte == `PREAMBLE_BYTE))
    else $error("transmit did not open with preamble");
  chk_byte_gap: assert property (
    tx_byte_stb && gap_ff != 16'h0000 |-> gap_ff == 16'(BC))
    else $error("byte spacing wrong");
  chk_carrier_tx: assert property (
    dac_static |-> bias_switch_output)
    else $error("static dac outside transmit");
  chk_radio_off: assert property (
    stb && addr == `S_RF_OFF && !reset_req |=> !bias_switch_output && !dac_static)
    else $error("radio off did not stop transmit");
endmodule
`default_nettype wire

// file: dv/tx_test_and_power_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_test_map.svh"
module tx_test_and_power_control_test;
  import tx_test_pkg::*;
  localparam int BC = 4;
  logic       clk;
  logic       rstn;
  byte_t      sw_addr;
  word_t      sw_wdata;
  logic       sw_wr;
  logic       sw_rd;
  word_t      sw_rdata;
  logic       sw_irq;
  mv_t        supply_mv;
  logic [4:0] pwr;
  logic       bypass;
  logic       osc_en;
  logic       bias;
  logic       dac_st;
  logic       sup_ok;
  byte_t      tx_b;
  logic       tx_stb;
  int         fails;
  int         cmp_count;
  byte_t      txq[$];
  radio_link_if lnk (.clk(clk));
  // host end with short waits
  rf_host_ctrl #(.REG_WAIT_CYC(10), .SETTLE_CYC(3)) u_rf_host_ctrl (
    .clk(clk), .rstn(rstn), .addr(sw_addr), .wdata(sw_wdata), .wr(sw_wr),
    .rd(sw_rd), .rdata(sw_rdata), .irq(sw_irq), .lnk(lnk));
  // device end with short byte period
  rf_test_power_ctrl #(.BYTE_CYCLES(BC)) u_rf_test_power_ctrl (
    .clk(clk), .rstn(rstn), .lnk(lnk), .supply_mv(supply_mv),
    .output_power_level(pwr), .oscillator_bypass(bypass), .osc_enabled(osc_en),
    .bias_switch_output(bias), .dac_static(dac_st), .supply_above_threshold(sup_ok),
    .tx_byte(tx_b), .tx_byte_stb(tx_stb));
  tx_link_checker #(.BC(BC)) u_tx_link_checker (
    .clk(clk), .rstn(rstn), .wr_en(lnk.wr_en), .stb(lnk.stb),
    .reset_req(lnk.reset_req), .addr(lnk.addr), .wdata(lnk.wdata),
    .regulator_enable_pin(lnk.regulator_enable_pin), .output_power_level(pwr),
    .oscillator_bypass(bypass), .bias_switch_output(bias), .dac_static(dac_st),
    .supply_above_threshold(sup_ok), .tx_byte(tx_b), .tx_byte_stb(tx_stb));
  // clock
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // collect every transmitted byte
  always @(posedge clk) begin
    if (tx_stb === 1'b1) txq.push_back(tx_b);
  end
  task automatic check(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw_write(input byte_t a, input word_t d);
    @(posedge clk);
    sw_wr    <= 1'b1;
    sw_addr  <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic sw_read(input byte_t a, output word_t d);
    @(posedge clk);
    sw_rd   <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    d = sw_rdata;
  endtask
  task automatic dev_write(input byte_t a, input word_t d);
    sw_write(`H_TARGET, {8'h00, a});
    sw_write(`H_WRITE, d);
  endtask
  task automatic dev_read(input byte_t a, output word_t d);
    sw_write(`H_TARGET, {8'h00, a});
    sw_write(`H_READ, 16'h0000);
    repeat (3) @(posedge clk);
    sw_read(`H_RESULT, d);
  endtask
  task automatic strobe(input byte_t c);
    sw_write(`H_STROBE, {8'h00, c});
  endtask
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 3000 && txq.size() < n; i++) @(posedge clk);
  endtask
  // power level through both host paths, unmapped places
  task automatic t_power;
    word_t d;
    check({11'h000, pwr}, 16'h001f);
    check({14'h0000, bias, dac_st}, 16'h0000);
    for (int i = 3; i < 32; i += 4) begin
      sw_write(`H_POWER, 16'(i));
      check({11'h000, pwr}, 16'(i));
      dev_read(`A_TX_CTRL, d);
      check(d, 16'ha0e0 | 16'(i));
    end
    dev_write(`A_TX_CTRL, 16'ha0fb);
    check({11'h000, pwr}, 16'h001b);
    dev_read(8'h3f, d);
    check(d, 16'h0000);
    sw_read(8'h0f, d);
    check(d, 16'h0000);
    sw_write(`H_CLKSRC, 16'h0001);
    check({15'h0000, bypass}, 16'h0001);
    dev_read(`A_MAIN, d);
    check(d & 16'h0001, 16'h0001);
    sw_write(`H_CLKSRC, 16'h0000);
    check({15'h0000, bypass}, 16'h0000);
    $display("test power done");
  endtask
  // supply monitor thresholds, ready interrupt, regulator off
  task automatic t_monitor;
    int    thr[4] = '{0, 0, 31, 31};
    int    mv[4]  = '{3334, 3333, 1899, 1898};
    word_t d;
    sw_write(`H_CTRL, 16'h0001);
    sw_read(`H_CTRL, d);
    check(d & 16'h0004, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      dev_write(`A_MONITOR, 16'h0020 | 16'(thr[i]));
      supply_mv <= 12'(mv[i]);
      repeat (6) @(posedge clk);
      check({15'h0000, sup_ok}, 16'(mv[i] * 27 > 1250 * (72 - thr[i])));
    end
    supply_mv <= 12'hbb8;
    repeat (6) @(posedge clk);
    check({15'h0000, sup_ok}, 16'h0001);
    dev_write(`A_MONITOR, 16'h001f);
    repeat (6) @(posedge clk);
    check({15'h0000, sup_ok}, 16'h0000);
    repeat (20) @(posedge clk);
    sw_read(`H_CTRL, d);
    check(d & 16'h0004, 16'h0004);
    sw_read(`H_ISTAT, d);
    check(d & 16'h0004, 16'h0004);
    check({15'h0000, sw_irq}, 16'h0000);
    sw_write(`H_IMASK, 16'h0004);
    check({15'h0000, sw_irq}, 16'h0001);
    sw_write(`H_ISTAT, 16'h0004);
    check({15'h0000, sw_irq}, 16'h0000);
    dev_read(`A_ISTAT, d);
    check(d & 16'h0004, 16'h0004);
    sw_write(`H_IMASK, 16'h0000);
    sw_write(`H_POWER, 16'h0003);
    sw_write(`H_CTRL, 16'h0000);
    check({11'h000, pwr}, 16'h001f);
    check({15'h0000, sup_ok}, 16'h0000);
    $display("test monitor done");
  endtask
  // carrier with pseudo-random data, then radio off
  task automatic t_prbs;
    byte_t exp[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'ha7, 8'h00, 8'h78, 8'hb8, 8'h4b};
    int    n;
    sw_write(`H_CTRL, 16'h0003);
    strobe(`S_OSC_ON);
    check({15'h0000, osc_en}, 16'h0001);
    dev_write(`A_MODEM, 16'h000c);
    dev_write(`A_DAC_OVR, `DAC_CARRIER);
    txq.delete();
    strobe(`S_TX_ON);
    wait_bytes(9);
    check({14'h0000, bias, dac_st}, 16'h0003);
    for (int i = 0; i < 9; i++) check({8'h00, txq[i]}, {8'h00, exp[i]});
    strobe(`S_RF_OFF);
    check({14'h0000, bias, dac_st}, 16'h0000);
    n = txq.size();
    repeat (20) @(posedge clk);
    check(16'(txq.size()), 16'(n));
    $display("test prbs done");
  endtask
  // looped buffer, one write past full, wrap at 128
  task automatic t_loop;
    sw_write(`H_CTRL, 16'h0003);
    check({14'h0000, bias, dac_st}, 16'h0000);
    dev_write(`A_MODEM, 16'h0008);
    sw_write(`H_TARGET, {8'h00, `A_TXBUF});
    for (int i = 0; i < 129; i++) sw_write(`H_WRITE, {8'h00, 8'(i) ^ 8'h5a});
    txq.delete();
    strobe(`S_TX_ON);
    wait_bytes(135);
    check({14'h0000, bias, dac_st}, 16'h0002);
    for (int i = 0; i < 130; i++) begin
      check({8'h00, txq[i + 5]}, {8'h00, {1'b0, 7'(i)} ^ 8'h5a});
    end
    check({8'h00, txq[4]}, {8'h00, `SFD_BYTE});
    strobe(`S_RF_OFF);
    check({15'h0000, bias}, 16'h0000);
    $display("test loop done");
  endtask
  // normal transmit after a looped test, empty buffer ends it
  task automatic t_normal;
    word_t d;
    dev_write(`A_MODEM, 16'h0000);
    dev_write(`A_IMASK, 16'h0002);
    sw_write(`H_TARGET, {8'h00, `A_TXBUF});
    sw_write(`H_WRITE, 16'h0011);
    sw_write(`H_WRITE, 16'h0022);
    txq.delete();
    strobe(`S_TX_ON);
    wait_bytes(7);
    repeat (8) @(posedge clk);
    check({14'h0000, bias, dac_st}, 16'h0000);
    check(16'(txq.size()), 16'h0007);
    check({txq[5], txq[6]}, 16'h1122);
    check({8'h00, txq[4]}, {8'h00, `SFD_BYTE});
    dev_read(`A_ISTAT, d);
    check(d, 16'h0003);
    sw_read(`H_ISTAT, d);
    check(d & 16'h0002, 16'h0002);
    dev_write(`A_ISTAT, 16'h0003);
    dev_read(`A_ISTAT, d);
    check(d, 16'h0000);
    $display("test normal done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
  // main sequence
  initial begin
    fails     = 0;
    cmp_count = 0;
    rstn      = 1'b0;
    sw_addr   = 8'h00;
    sw_wdata  = 16'h0000;
    sw_wr     = 1'b0;
    sw_rd     = 1'b0;
    supply_mv = 12'he10;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_power();
    t_monitor();
    t_prbs();
    t_loop();
    t_normal();
    end_sim();
  end
endmodule
`default_nettype wire
